// File: bench/wdtdt_tb_top.sv
// self-checking bench for the dual-timeout watchdog
`timescale 1ns/10ps
module wdtdt_tb_top;
  import wdtdt_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic soft_rst_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [SEL_W-1:0] wb_sel_i = '0;
  logic [DATA_W-1:0] wb_dat_i = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_ff;
  logic sys_rst_ff;
  int bad_count = 0;
  int checks_done = 0;
  logic [DATA_W-1:0] rd;
  // shortened top keeps the run short: setting 15 gives 2^12 ticks
  localparam int TB_TOP = 27;
  // two clock cycles per peripheral tick
  localparam int INT_CYC = 2 * (1 << (TB_TOP - 15));
  localparam int RST_CYC = 2 * (1 << (TB_TOP - 14));

  always #2.5 ref_clk = ~ref_clk;

  wdtdt_top #(
    .TOP_BIT(TB_TOP)
  ) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .soft_rst_i(soft_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_ff(irq_ff),
    .sys_rst_ff(sys_rst_ff)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr,
                         input logic [DATA_W-1:0] dat);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n == 50) begin
      bad_count++;
      stop_test();
    end
  endtask : wb_xfer

  task automatic feed();
    wb_xfer(1'b1, OFF_FEED, KEY_FIRST);
    wb_xfer(1'b1, OFF_FEED, KEY_SECOND);
  endtask : feed

  task automatic t_por();
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h00000000);
    wb_xfer(1'b0, OFF_FEED, '0);
    chk(rd, 32'h00000000);
    wb_xfer(1'b0, 8'h10, '0);
    chk(rd, 32'h00000000);
    $display("test por done");
  endtask : t_por

  task automatic t_key();
    // enable without a key pair must not take
    wb_xfer(1'b1, OFF_CTRL, 32'h00000100);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd & 32'h00000100, 32'h00000000);
    // a stray value between the keys spoils the pair
    wb_xfer(1'b1, OFF_FEED, KEY_FIRST);
    wb_xfer(1'b1, OFF_FEED, 32'h00000033);
    wb_xfer(1'b1, OFF_FEED, KEY_SECOND);
    wb_xfer(1'b1, OFF_CTRL, 32'h00000100);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd & 32'h00000100, 32'h00000000);
    feed();
    // interrupt period shorter than the reset period
    wb_xfer(1'b1, OFF_CTRL, 32'h00000DEF);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h00000DEF);
    $display("test key done");
  endtask : t_key

  task automatic t_time();
    int n;
    int irq_at;
    int rst_at;
    irq_at = -1;
    rst_at = -1;
    // a late feed must move both expiries to count from itself
    repeat (1000) @(posedge ref_clk);
    feed();
    for (n = 0; n < RST_CYC + 100 && rst_at < 0; n++) begin
      @(posedge ref_clk);
      #1;
      if (irq_ff === 1'b1 && irq_at < 0) irq_at = n;
      if (sys_rst_ff === 1'b1) rst_at = n;
    end
    if (rst_at < 0) begin
      bad_count++;
      stop_test();
    end
    chk({31'h0, irq_at > INT_CYC - 10 && irq_at < INT_CYC + 10}, 32'h1);
    chk({31'h0, rst_at > RST_CYC - 10 && rst_at < RST_CYC + 10}, 32'h1);
    chk({31'h0, irq_at >= 0 && irq_at < rst_at}, 32'h1);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd & 32'h80000D00, 32'h80000D00);
    $display("test timeout done");
  endtask : t_time

  task automatic t_rst();
    @(posedge ref_clk);
    soft_rst_i <= 1'b1;
    @(posedge ref_clk);
    soft_rst_i <= 1'b0;
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd & 32'h00000100, 32'h00000100);
    wb_xfer(1'b1, OFF_CTRL, 32'h00000DFF);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd & 32'h80000000, 32'h00000000);
    wb_xfer(1'b1, OFF_CTRL, 32'h00000CFF);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd & 32'h00000100, 32'h00000000);
    chk({30'h0, irq_ff, sys_rst_ff}, 32'h0);
    // power-on reset drops periods, bit 10 and bit 11; the enable bit is already off here
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h00000000);
    $display("test resets done");
  endtask : t_rst

  task automatic t_flag();
    int n;
    int hits;
    hits = 0;
    // stopped right after enabling: neither event may follow
    feed();
    wb_xfer(1'b1, OFF_CTRL, 32'h00000DFF);
    wb_xfer(1'b1, OFF_CTRL, 32'h00000CFF);
    for (n = 0; n < INT_CYC + 200; n++) begin
      @(posedge ref_clk);
      #1;
      if (irq_ff !== 1'b0 || sys_rst_ff !== 1'b0) hits++;
    end
    chk(hits, 32'h0);
    // the flag latches while the request stays gated off
    feed();
    wb_xfer(1'b1, OFF_CTRL, 32'h0000010F);
    repeat (INT_CYC + 20) @(posedge ref_clk);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h0000030F);
    #1;
    chk({31'h0, irq_ff}, 32'h0);
    wb_xfer(1'b1, OFF_CTRL, 32'h0000050F);
    #1;
    chk({31'h0, irq_ff}, 32'h1);
    // writing one to the flag clears it and drops the request
    wb_xfer(1'b1, OFF_CTRL, 32'h0000070F);
    #1;
    chk({31'h0, irq_ff}, 32'h0);
    wb_xfer(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h0000050F);
    $display("test flag done");
  endtask : t_flag

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_por();
    t_key();
    t_time();
    t_rst();
    t_flag();
    stop_test();
  end
endmodule : wdtdt_tb_top

// File: hdl/wdtdt_pkg.sv
// constants shared by the dual-timeout watchdog
package wdtdt_pkg;
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;
  localparam int SEL_W = 4;
  localparam int CNT_W = 32;
  localparam int PER_W = 4;
  localparam int CNT_TOP = 31;
  // peripheral clock is the system clock divided by this
  localparam int PCLK_DIV = 2;
  localparam int REF_CLK_HZ = 200000000;
  localparam int PCLK_HZ = REF_CLK_HZ / PCLK_DIV;

  localparam logic [ADR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFF_FEED = 8'h04;

  localparam logic [DATA_W-1:0] KEY_FIRST = 32'h000000A5;
  localparam logic [DATA_W-1:0] KEY_SECOND = 32'h0000005A;

  localparam int BIT_INT_PER = 0;
  localparam int BIT_RST_PER = 4;
  localparam int BIT_WDT_EN = 8;
  localparam int BIT_INT_FLAG = 9;
  localparam int BIT_INT_EN = 10;
  localparam int BIT_RST_EN = 11;
  localparam int BIT_RST_FLAG = 31;

  localparam logic [PER_W-1:0] PER_RST = 4'h0;
  localparam logic [PER_W-1:0] PER_OFF = 4'h0;

  typedef enum logic {KEY_IDLE, KEY_HALF} wdtdt_key_type;
endpackage : wdtdt_pkg

// File: hdl/wdtdt_tap.sv
// peripheral-clock tick, watchdog counter and the two expiry taps
`timescale 1ns/10ps
module wdtdt_tap #(
  // power of two of the longest timeout; lowered only to shorten runs
  parameter int TOP_BIT = wdtdt_pkg::CNT_TOP
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [wdtdt_pkg::PER_W-1:0] int_period,
  input wire logic [wdtdt_pkg::PER_W-1:0] rst_period,
  // expiry pulses and count
  output logic int_hit_ff,
  output logic rst_hit_ff,
  output logic [wdtdt_pkg::CNT_W-1:0] cnt_ff
);
  import wdtdt_pkg::*;

  logic tick_ff;
  logic nxt_tick;
  logic nxt_int_hit;
  logic nxt_rst_hit;
  logic [CNT_W-1:0] nxt_cnt;

  // threshold 2^(TOP_BIT - period) peripheral cycles
  function automatic logic [CNT_W-1:0] thr(input logic [PER_W-1:0] p);
    logic [CNT_W-1:0] one;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    thr = one << (TOP_BIT - int'(p));
  endfunction : thr

  always_comb begin
    nxt_tick = ~tick_ff;
    nxt_cnt = cnt_ff;
    nxt_int_hit = 1'b0;
    nxt_rst_hit = 1'b0;
    if (clear) begin
      nxt_cnt = '0;
      nxt_tick = 1'b0;
    end else if (run && tick_ff) begin
      nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      nxt_int_hit = (nxt_cnt == thr(int_period));
      nxt_rst_hit = (nxt_cnt == thr(rst_period));
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 1'b0;
      cnt_ff <= '0;
      int_hit_ff <= 1'b0;
      rst_hit_ff <= 1'b0;
    end else if (ce) begin
      tick_ff <= nxt_tick;
      cnt_ff <= nxt_cnt;
      int_hit_ff <= nxt_int_hit;
      rst_hit_ff <= nxt_rst_hit;
    end
  end

  a_int_tap_exact: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    int_hit_ff |-> cnt_ff == thr(int_period))
    else $error("interrupt tap fired off its threshold");
  a_rst_tap_exact: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rst_hit_ff |-> cnt_ff == thr(rst_period))
    else $error("reset tap fired off its threshold");
  a_clear_zeroes: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && clear |=> cnt_ff == '0 && !int_hit_ff && !rst_hit_ff)
    else $error("counter not cleared");
  a_half_rate: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && !clear && cnt_ff != $past(cnt_ff) |=> cnt_ff == $past(cnt_ff)
      || !ce || clear)
    else $error("counter advanced on two edges in a row");
endmodule : wdtdt_tap

// File: hdl/wdtdt_top.sv
// dual-timeout watchdog with a classic wishbone register slave
//
// Contract
// - interrupt raised after interrupt period without restart
// - system reset after reset period without restart
// - interrupt timeout is 2^(31-setting) peripheral cycles; setting 0 turns the interrupt off
// - reset timeout is 2^(31-setting) peripheral cycles
// - sixteen settings span 2^16 to 2^31
// - counter cleared by every reset, own included
// - enable accepted only after the key pair
// - completed key pair restarts the counter
// - writing zero to enable stops both events
// - power-on reset clears the enable bit
// - other resets leave the enable bit alone
// - readable flag marks a watchdog-caused reset
// - control at 0x0, feed key at 0x4
// - bit 9 sticky flag, bit 10 gates request
// - bit 11 reset enable, bit 8 enable
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module wdtdt_top #(
  // power of two of the longest timeout; lowered only to shorten runs
  parameter int TOP_BIT = wdtdt_pkg::CNT_TOP
) (
  // clock, power-on reset, clock enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // non-power-on system reset from the reset controller
  input wire logic soft_rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [wdtdt_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [wdtdt_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [wdtdt_pkg::DATA_W-1:0] wb_dat_i,
  output logic [wdtdt_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // watchdog events
  output logic irq_ff,
  output logic sys_rst_ff
);
  import wdtdt_pkg::*;

  logic ack_ff, nxt_ack;
  logic [DATA_W-1:0] dat_ff, nxt_dat;
  logic wdt_en_ff, nxt_wdt_en;
  logic int_en_ff, nxt_int_en;
  logic rst_en_ff, nxt_rst_en;
  logic int_flag_ff, nxt_int_flag;
  logic rst_flag_ff, nxt_rst_flag;
  logic armed_ff, nxt_armed;
  logic [PER_W-1:0] int_per_ff, nxt_int_per;
  logic [PER_W-1:0] rst_per_ff, nxt_rst_per;
  logic nxt_irq, nxt_sys_rst;
  wdtdt_key_type key_ff, nxt_key;

  logic take, wr_ctrl, wr_feed, rd_ctrl;
  logic restart, soft_any, int_hit, rst_hit;
  logic [DATA_W-1:0] wdata, ctrl_view;
  logic [CNT_W-1:0] cnt;

  // expand byte lanes so partial writes only touch selected bytes
  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [SEL_W-1:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < SEL_W; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    lane_mask = m;
  endfunction : lane_mask

  // new request taken only while ack is low; ack rises the next cycle and drops after one cycle
  assign take = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wdata = wb_dat_i & lane_mask(wb_sel_i);
  assign soft_any = soft_rst_i || sys_rst_ff;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_feed = 1'b0;
    rd_ctrl = 1'b0;
    if (take && wb_adr_i == OFF_CTRL) begin
      wr_ctrl = wb_we_i;
      rd_ctrl = !wb_we_i;
    end else if (take && wb_adr_i == OFF_FEED) begin
      wr_feed = wb_we_i;
    end
  end

  always_comb begin
    ctrl_view = '0;
    ctrl_view[BIT_INT_PER +: PER_W] = int_per_ff;
    ctrl_view[BIT_RST_PER +: PER_W] = rst_per_ff;
    ctrl_view[BIT_WDT_EN] = wdt_en_ff;
    ctrl_view[BIT_INT_FLAG] = int_flag_ff;
    ctrl_view[BIT_INT_EN] = int_en_ff;
    ctrl_view[BIT_RST_EN] = rst_en_ff;
    ctrl_view[BIT_RST_FLAG] = rst_flag_ff;
  end

  // feed key sequencing
  always_comb begin
    nxt_key = key_ff;
    restart = 1'b0;
    if (soft_any) begin
      nxt_key = KEY_IDLE;
    end else if (wr_feed) begin
      case (key_ff)
        KEY_IDLE: begin
          nxt_key = (wdata == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
        KEY_HALF: begin
          if (wdata == KEY_SECOND) begin
            restart = 1'b1;
            nxt_key = KEY_IDLE;
          end else if (wdata == KEY_FIRST) begin
            nxt_key = KEY_HALF;
          end else begin
            nxt_key = KEY_IDLE;
          end
        end
        default: nxt_key = KEY_IDLE;
      endcase
    end
  end

  wdtdt_tap #(
    .TOP_BIT(TOP_BIT)
  ) u_tap (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .run(wdt_en_ff),
    .clear(restart || soft_any),
    .int_period(int_per_ff),
    .rst_period(rst_per_ff),
    .int_hit_ff(int_hit),
    .rst_hit_ff(rst_hit),
    .cnt_ff(cnt)
  );

  always_comb begin
    nxt_ack = take;
    nxt_dat = rd_ctrl ? ctrl_view : '0;
    nxt_wdt_en = wdt_en_ff;
    nxt_int_en = int_en_ff;
    nxt_rst_en = rst_en_ff;
    nxt_int_per = int_per_ff;
    nxt_rst_per = rst_per_ff;
    nxt_int_flag = int_flag_ff;
    nxt_rst_flag = rst_flag_ff;
    nxt_armed = armed_ff;
    if (restart) begin
      nxt_armed = 1'b1;
    end
    if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        nxt_int_per = wdata[BIT_INT_PER +: PER_W];
        nxt_rst_per = wdata[BIT_RST_PER +: PER_W];
      end
      if (wb_sel_i[1]) begin
        nxt_int_en = wdata[BIT_INT_EN];
        nxt_rst_en = wdata[BIT_RST_EN];
        if (!wdata[BIT_WDT_EN]) begin
          nxt_wdt_en = 1'b0;
        end else if (armed_ff && !wdt_en_ff) begin
          nxt_wdt_en = 1'b1;
          nxt_armed = 1'b0;
        end
        if (wdata[BIT_INT_FLAG]) begin
          nxt_int_flag = 1'b0;
        end
      end
      if (wb_sel_i[SEL_W-1] && !wdata[BIT_RST_FLAG]) begin
        nxt_rst_flag = 1'b0;
      end
    end
    // a partial key pair or a pending interrupt does not survive a reset;
    // enable and reset enable do, so the watchdog keeps guarding
    if (soft_any) begin
      nxt_armed = 1'b0;
      nxt_int_flag = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (int_hit && wdt_en_ff && int_per_ff != PER_OFF) begin
      nxt_int_flag = 1'b1;
    end
    nxt_sys_rst = rst_hit && wdt_en_ff && rst_en_ff;
    if (nxt_sys_rst) begin
      nxt_rst_flag = 1'b1;
    end
    nxt_irq = nxt_int_flag && nxt_int_en && nxt_wdt_en;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
      wdt_en_ff <= 1'b0;
      int_en_ff <= 1'b0;
      rst_en_ff <= 1'b0;
      int_per_ff <= PER_RST;
      rst_per_ff <= PER_RST;
      int_flag_ff <= 1'b0;
      rst_flag_ff <= 1'b0;
      armed_ff <= 1'b0;
      key_ff <= KEY_IDLE;
      irq_ff <= 1'b0;
      sys_rst_ff <= 1'b0;
    end else if (ce) begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      wdt_en_ff <= nxt_wdt_en;
      int_en_ff <= nxt_int_en;
      rst_en_ff <= nxt_rst_en;
      int_per_ff <= nxt_int_per;
      rst_per_ff <= nxt_rst_per;
      int_flag_ff <= nxt_int_flag;
      rst_flag_ff <= nxt_rst_flag;
      armed_ff <= nxt_armed;
      key_ff <= nxt_key;
      irq_ff <= nxt_irq;
      sys_rst_ff <= nxt_sys_rst;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  sequence s_key_half;
    ce && wr_feed && key_ff == KEY_HALF;
  endsequence
  sequence s_pair_done;
    s_key_half and (wdata == KEY_SECOND);
  endsequence
  sequence s_bad_key;
    ce && wr_feed && wdata != KEY_FIRST && wdata != KEY_SECOND;
  endsequence

  a_int_raise: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && int_hit && wdt_en_ff && int_per_ff != PER_OFF |=> int_flag_ff)
    else $error("interrupt flag missed an expiry");
  a_int_off_zero: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && $rose(int_flag_ff) |-> $past(int_per_ff) != PER_OFF)
    else $error("interrupt flag set with period zero");
  a_irq_gate: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    irq_ff |-> int_flag_ff && int_en_ff)
    else $error("interrupt request without flag and enable");
  a_sysrst_fire: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && rst_hit && wdt_en_ff && rst_en_ff
      |=> sys_rst_ff && rst_flag_ff ##1 (!sys_rst_ff || !ce))
    else $error("system reset not issued as one pulse");
  a_quiet_off: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(sys_rst_ff) |-> $past(wdt_en_ff))
    else $error("reset raised while disabled");
  a_enable_key: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(wdt_en_ff) |-> $past(armed_ff) && $past(wr_ctrl))
    else $error("enable taken without key pair");
  a_pair_restart: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_pair_done |=> cnt == '0 && key_ff == KEY_IDLE)
    else $error("key pair did not restart the counter");
  a_bad_discard: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_bad_key |=> key_ff == KEY_IDLE)
    else $error("partial key pair survived a bad write");
  a_keep_enable: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && soft_any && wdt_en_ff && !wr_ctrl |=> wdt_en_ff && cnt == '0)
    else $error("reset dropped enable or kept count");
  a_ack_pulse: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ce && take |=> wb_ack_o ##1 (!wb_ack_o || !ce))
    else $error("bus answer not a single cycle");
endmodule : wdtdt_top
